// *** design/pc_unit_map.svh ***
// register offsets, field positions, reset values and widths for the program counter unit
`ifndef PC_UNIT_MAP_SVH
`define PC_UNIT_MAP_SVH
`define PCU_LOW_BYTE_OFS    12'h000
`define PCU_HIGH_LATCH_OFS  12'h004
`define PCU_CTRL_OFS        12'h008
`define PCU_STATUS_OFS      12'h00C
`define PCU_PC_W            13
`define PCU_HI_W            5
`define PCU_JUMP_W          11
`define PCU_STACK_DEPTH     8
`define PCU_PAGE_MSB        4
`define PCU_PAGE_LSB        3
`define PCU_PC_RESET        13'h0000
`define PCU_LATCH_RESET     8'h00
`define PCU_MEM_8K          2'h2
`endif

// *** design/pc_unit_pkg.sv ***
// types shared by the program counter unit
package pc_unit_pkg;
  typedef enum logic [2:0] {OP_NONE, OP_STEP, OP_JUMP, OP_CALL, OP_RET, OP_IRQ} pc_op_t;
  typedef enum logic [1:0] {MEM_2K, MEM_4K, MEM_8K} mem_size_t;
endpackage

// *** design/stack_if.sv ***
// push/pop carrier between the counter and the return stack
`timescale 1ns/1ps
interface stack_if #(parameter int W = 13);
  logic         push;
  logic         pop;
  logic [W-1:0] push_data;
  logic [W-1:0] top_data;
  modport ctrl (output push, output pop, output push_data, input top_data);
  modport stk  (input push, input pop, input push_data, output top_data);
endinterface

// *** design/return_stack.sv ***
// circular return-address stack with hidden pointer
`timescale 1ns/1ps
module return_stack #(
  parameter int W     = 13,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // stack port
  stack_if.stk      s
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0]  mem_reg [DEPTH];
  logic [PW-1:0] ptr_reg;

  // pointer wraps both ways, no overflow or underflow flag exists
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      ptr_reg <= '0;
    else if (s.push)
      ptr_reg <= ptr_reg + PW'(1);
    else if (s.pop)
      ptr_reg <= ptr_reg - PW'(1);
  end

  // ninth push lands on the slot of the first
  always_ff @(posedge clk_i)
  begin
    if (s.push)
      mem_reg[ptr_reg] <= s.push_data;
  end

  assign s.top_data = mem_reg[ptr_reg - PW'(1)];

  chk_ptr_wrap: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s.pop && !s.push && ptr_reg == '0 |=> ptr_reg == PW'(DEPTH - 1))
    else $error("stack pointer did not wrap on pop");
endmodule // return_stack

// *** design/pc_unit.sv ***
// program counter, high latch, paging and return stack control with APB access
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "pc_unit_map.svh"
module pc_unit #(
  parameter int                     PC_W     = `PCU_PC_W,
  parameter int                     DEPTH    = `PCU_STACK_DEPTH,
  parameter pc_unit_pkg::mem_size_t MEM_SIZE = pc_unit_pkg::MEM_8K
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic                   pready_o,
  output logic      [31:0]       prdata_o,
  output logic                   pslverr_o,
  // decoder side
  input  wire pc_unit_pkg::pc_op_t op_i,
  input  wire logic [10:0]       jump_addr_i,
  input  wire logic [PC_W-1:0]   vector_i,
  // fetch address
  output logic      [PC_W-1:0]   pc_o
);
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [7:0]      latch_reg;
  logic            halt_reg;
  logic            wr_en;
  logic            rd_en;
  logic            low_wr;
  logic [1:0]      page_bits;
  logic [PC_W-1:0] ret_addr;

  stack_if #(.W(PC_W)) stk ();

  return_stack #(.W(PC_W), .DEPTH(DEPTH)) u_stack (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .s        (stk)
  );

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  // zero-wait slave: every access completes in its first access cycle
  assign pready_o  = 1'b1;
  assign wr_en     = psel_i && penable_i && pwrite_i;
  assign rd_en     = psel_i && penable_i && !pwrite_i;
  assign pslverr_o = psel_i && penable_i && !(addr_hit(paddr_i, `PCU_LOW_BYTE_OFS)
                     || addr_hit(paddr_i, `PCU_HIGH_LATCH_OFS) || addr_hit(paddr_i, `PCU_CTRL_OFS)
                     || addr_hit(paddr_i, `PCU_STATUS_OFS));
  assign low_wr    = wr_en && pstrb_i[0] && addr_hit(paddr_i, `PCU_LOW_BYTE_OFS);

  // small parts drop latch bit 4 as a page bit
  assign page_bits = (MEM_SIZE == pc_unit_pkg::MEM_8K) ? latch_reg[`PCU_PAGE_MSB:`PCU_PAGE_LSB]
                                                       : {1'b0, latch_reg[`PCU_PAGE_LSB]};
  // return address of a call is the next instruction after it; an interrupt pushes the replaced instruction itself
  assign ret_addr  = pc_reg + PC_W'(1);

  // stack requests from the decoder
  assign stk.push      = !halt_reg && (op_i == pc_unit_pkg::OP_CALL || op_i == pc_unit_pkg::OP_IRQ);
  assign stk.pop       = !halt_reg && op_i == pc_unit_pkg::OP_RET;
  assign stk.push_data = (op_i == pc_unit_pkg::OP_IRQ) ? pc_reg : ret_addr;

  always_comb
  begin
    pc_next = pc_reg;
    if (low_wr)
      pc_next = {latch_reg[`PCU_HI_W-1:0], pwdata_i[7:0]};
    else if (!halt_reg)
    begin
      unique case (op_i)
        pc_unit_pkg::OP_NONE: pc_next = pc_reg;
        pc_unit_pkg::OP_STEP: pc_next = ret_addr;
        pc_unit_pkg::OP_JUMP,
        pc_unit_pkg::OP_CALL: pc_next = {page_bits, jump_addr_i};
        pc_unit_pkg::OP_RET:  pc_next = stk.top_data;
        pc_unit_pkg::OP_IRQ:  pc_next = vector_i;
        default:              pc_next = pc_reg;
      endcase
    end
  end

  // every reset clears the counter including its hidden high bits
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      pc_reg <= `PCU_PC_RESET;
    else
      pc_reg <= pc_next;
  end

  // only software changes the latch; stack traffic never does
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      latch_reg <= `PCU_LATCH_RESET;
    else if (wr_en && pstrb_i[0] && addr_hit(paddr_i, `PCU_HIGH_LATCH_OFS))
      latch_reg <= pwdata_i[7:0];
  end

  // control bit 0 freezes the decoder side so software can poke the counter
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      halt_reg <= 1'b0;
    else if (wr_en && pstrb_i[0] && addr_hit(paddr_i, `PCU_CTRL_OFS))
      halt_reg <= pwdata_i[0];
  end

  // high counter bits never appear on the bus; no stack status either
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      prdata_o <= 32'h0000_0000;
    else if (psel_i && !penable_i && !pwrite_i)
    begin
      if (addr_hit(paddr_i, `PCU_LOW_BYTE_OFS))
        prdata_o <= {24'h00_0000, pc_reg[7:0]};
      else if (addr_hit(paddr_i, `PCU_HIGH_LATCH_OFS))
        prdata_o <= {24'h00_0000, latch_reg};
      else if (addr_hit(paddr_i, `PCU_CTRL_OFS))
        prdata_o <= {31'h0000_0000, halt_reg};
      else if (addr_hit(paddr_i, `PCU_STATUS_OFS))
        prdata_o <= {31'h0000_0000, !halt_reg};
      else
        prdata_o <= 32'h0000_0000;
    end
  end

  assign pc_o = pc_reg;

  logic unused_rd;
  assign unused_rd = rd_en;

  chk_low_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    low_wr |=> pc_reg == {$past(latch_reg[4:0]), $past(pwdata_i[7:0])})
    else $error("low byte write did not load latch into counter");
  chk_jump_page: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !low_wr && !halt_reg && op_i == pc_unit_pkg::OP_JUMP |=> pc_reg[10:0] == $past(jump_addr_i)
      && pc_reg[12:11] == $past(page_bits))
    else $error("jump target not formed from page bits and instruction");
  chk_reset_clear: assert property (@(posedge clk_i)
    !resetn_i |=> pc_reg[12:8] == 5'h00)
    else $error("reset left high counter bits set");
  chk_call_return: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !low_wr && !halt_reg && op_i == pc_unit_pkg::OP_CALL ##1 !low_wr && !halt_reg
      && op_i == pc_unit_pkg::OP_RET |=> pc_reg == $past(pc_reg, 2) + 13'h0001)
    else $error("return did not restore address after call");
  chk_latch_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (stk.push || stk.pop) && !wr_en |=> $stable(latch_reg))
    else $error("stack operation changed the high latch");
  chk_irq_vector: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !low_wr && !halt_reg && op_i == pc_unit_pkg::OP_IRQ |=> pc_reg == $past(vector_i))
    else $error("interrupt did not branch to vector");
  chk_small_page: assert property (@(posedge clk_i) disable iff (!resetn_i)
    MEM_SIZE != pc_unit_pkg::MEM_8K |-> page_bits[1] == 1'b0)
    else $error("small part used latch bit 4 as page bit");
  chk_read_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
    psel_i && !penable_i && !pwrite_i && addr_hit(paddr_i, `PCU_LOW_BYTE_OFS) |=> prdata_o[31:8] == 24'h00_0000)
    else $error("high counter bits visible on read");

  cov_call: cover property (@(posedge clk_i) stk.push && op_i == pc_unit_pkg::OP_CALL);
  cov_ret: cover property (@(posedge clk_i) stk.pop);
  cov_irq: cover property (@(posedge clk_i) stk.push && op_i == pc_unit_pkg::OP_IRQ);
  cov_low_wr: cover property (@(posedge clk_i) low_wr);
endmodule // pc_unit

// *** tb/decoder_model.sv ***
// decoder-side model issuing one operation at a time
`timescale 1ns/1ps
module decoder_model (
  // clock
  input  wire logic               clk_i,
  // decoder outputs
  output pc_unit_pkg::pc_op_t     op_o,
  output logic [10:0]             jump_addr_o,
  output logic [12:0]             vector_o
);
  initial
  begin
    op_o        = pc_unit_pkg::OP_NONE;
    jump_addr_o = 11'h000;
    vector_o    = 13'h0004;
  end
  // idle fields show the inverse so that a stale value is never trusted
  task automatic issue(input pc_unit_pkg::pc_op_t op, input logic [10:0] a, input logic [12:0] v);
    @(posedge clk_i);
    op_o        <= op;
    jump_addr_o <= a;
    vector_o    <= v;
    @(posedge clk_i);
    op_o        <= pc_unit_pkg::OP_NONE;
    jump_addr_o <= ~a;
    vector_o    <= ~v;
  endtask
  // two operations on consecutive edges, no idle cycle between them
  task automatic issue_pair(input pc_unit_pkg::pc_op_t op1, input logic [10:0] a1,
                            input pc_unit_pkg::pc_op_t op2, input logic [10:0] a2);
    @(posedge clk_i);
    op_o        <= op1;
    jump_addr_o <= a1;
    @(posedge clk_i);
    op_o        <= op2;
    jump_addr_o <= a2;
    @(posedge clk_i);
    op_o        <= pc_unit_pkg::OP_NONE;
    jump_addr_o <= ~a2;
  endtask
endmodule // decoder_model

// *** tb/program_counter_stack_paging_tb.sv ***
// self-checking bench for the program counter unit
`timescale 1ns/1ps
module program_counter_stack_paging_tb;
  logic clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [12:0] pc_o, vector_i, exp_pc, pc_small;
  logic [10:0] jump_addr_i;
  logic [12:0] stk [8];
  pc_unit_pkg::pc_op_t op_i;
  int bad_count, checks, sp;
  pc_unit u_pc_unit (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .op_i(op_i), .jump_addr_i(jump_addr_i),
    .vector_i(vector_i), .pc_o(pc_o));
  // a 4K-word part on the same bus, to see latch bit 4 ignored as a page bit
  pc_unit #(.MEM_SIZE(pc_unit_pkg::MEM_4K)) u_pc_unit_4k (.clk_i(clk_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(4'hF), .pready_o(), .prdata_o(), .pslverr_o(), .op_i(op_i), .jump_addr_i(jump_addr_i),
    .vector_i(vector_i), .pc_o(pc_small));
  decoder_model u_decoder_model (.clk_i(clk_i), .op_o(op_i), .jump_addr_o(jump_addr_i), .vector_o(vector_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic op(input pc_unit_pkg::pc_op_t o, input logic [10:0] a, input logic [12:0] v);
    u_decoder_model.issue(o, a, v);
    #1 chk(32'(pc_o), 32'(exp_pc));
  endtask
  task automatic conclude();
    if (bad_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial
  begin
    #20_000;
    bad_count++;
    conclude();
  end
  initial
  begin
    {resetn_i, psel_i, penable_i, pwrite_i} = 4'h0;
    paddr_i  = 12'h000;
    pwdata_i = 32'h0000_0000;
    bad_count = 0;
    checks = 0;
    sp = 0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1 chk(32'(pc_o), 32'h0000_0000);
    apb(1'b1, 12'h004, 32'h0000_001F);
    apb(1'b1, 12'h000, 32'h0000_0034);
    #1 chk(32'(pc_o), 32'h0000_1F34);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0034);
    chk({31'h0000_0000, pready_o}, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_0018);
    exp_pc = 13'h1923;
    op(pc_unit_pkg::OP_JUMP, 11'h123, 13'h0000);
    chk(32'(pc_small), 32'h0000_0923);
    exp_pc = 13'h1924;
    op(pc_unit_pkg::OP_STEP, 11'h000, 13'h0000);
    // computed jump 0x24 + 0xE0 writes low byte 0x04; the high bits come from the latch (0x18), not the old counter
    apb(1'b1, 12'h000, 32'h0000_0004);
    #1 chk(32'(pc_o), 32'h0000_1804);
    exp_pc = 13'h1804;
    // nine calls: the ninth lands on the first slot
    for (int i = 0; i < 9; i++)
    begin
      stk[sp % 8] = exp_pc + 13'h0001;
      sp++;
      exp_pc = 13'h1900 + 13'(i);
      op(pc_unit_pkg::OP_CALL, 11'h100 + 11'(i), 13'h0000);
    end
    for (int i = 0; i < 9; i++)
    begin
      sp--;
      exp_pc = stk[sp % 8];
      op(pc_unit_pkg::OP_RET, 11'h000, 13'h0000);
    end
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0018);
    stk[0] = exp_pc;
    exp_pc = 13'h0004;
    op(pc_unit_pkg::OP_IRQ, 11'h000, 13'h0004);
    exp_pc = stk[0];
    op(pc_unit_pkg::OP_RET, 11'h000, 13'h0000);
    exp_pc = exp_pc + 13'h0001;
    u_decoder_model.issue_pair(pc_unit_pkg::OP_CALL, 11'h055, pc_unit_pkg::OP_RET, 11'h000);
    #1 chk(32'(pc_o), 32'(exp_pc));
    // halted: decoder operations are ignored
    apb(1'b1, 12'h008, 32'h0000_0001);
    op(pc_unit_pkg::OP_JUMP, 11'h3AA, 13'h0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 12'h008, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    conclude();
  end
endmodule // program_counter_stack_paging_tb
